//--- bench/exrn_src_model.sv
// Model of the external non-maskable interrupt sources
`timescale 1ns/1ps
module exrn_src_model (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Requests from the bench
	input  wire logic pin_req,
	input  wire logic msg_req,
	// Lines into the unit
	output logic      nmi_pin,
	output logic      nmi_msg
);
	logic [1:0] hold_q;
	// Pin held two cycles then back to idle low; message one cycle wide
	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_q  <= 2'h0;
			nmi_msg <= 1'b0;
		end else begin
			hold_q  <= pin_req ? 2'h2 : hold_q - {1'b0, |hold_q};
			nmi_msg <= msg_req;
		end
	end
	assign nmi_pin = |hold_q;
endmodule // exrn_src_model

//--- bench/exrn_unit_tb.sv
// Self-checking bench for the exception and non-maskable unit
`timescale 1ns/1ps
module exrn_unit_tb;
	import exrn_pkg::*;
	logic mclk, rst, ret_valid, ret_boundary, ret_spec, ret_taken, ret_rep;
	logic ret_rep_last, ret_interrupt_return_instruction, exc_valid, exc_gpr_dirty, gate_is_maskable_interrupt_pin;
	logic maskable_interrupt_pin, pin_req, msg_req, nmi_pin, nmi_msg, vec2;
	logic dlv_valid, dlv_restartable, dlv_precise, dlv_clear_ie, rollback;
	logic save_regs, int_ack, nmi_blocked, in_nmi_handler;
	logic [AW-1:0] ret_ip, ret_next_ip, ret_target_ip, dlv_return_ip, rip;
	logic [VW-1:0] exc_vector, int_vector, dlv_vector;
	logic [FW-1:0] flags_register;
	exrn_class_t   exc_class;
	exrn_kind_t    dlv_kind;
	int            seed = 96827;
	int            errors = 0;
	int            comparisons = 0;

	exrn_unit u_exrn_unit (.mclk, .rst, .ret_valid, .ret_boundary, .ret_spec,
		.ret_ip, .ret_next_ip, .ret_taken, .ret_target_ip, .ret_rep,
		.ret_rep_last, .ret_interrupt_return_instruction, .exc_valid, .exc_class, .exc_vector,
		.exc_gpr_dirty, .nmi_pin, .nmi_msg, .maskable_interrupt_pin,
		.int_vector, .flags_register, .gate_is_maskable_interrupt_pin, .dlv_valid, .dlv_kind,
		.dlv_vector, .dlv_return_ip, .dlv_restartable, .dlv_precise,
		.dlv_clear_ie, .rollback, .save_regs, .int_ack, .nmi_blocked,
		.in_nmi_handler);
	exrn_src_model u_exrn_src_model (.mclk, .rst, .pin_req, .msg_req,
		.nmi_pin, .nmi_msg);

	// Clock at 25 MHz
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [AW-1:0] s, e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Present one retiring instruction; flag bit 9 is the enable
	task automatic arm(input logic e, b, ie);
		logic [31:0] r;
		@(posedge mclk);
		r = $random(seed);
		ret_valid      <= 1'b1;
		ret_boundary   <= b;
		exc_valid      <= e;
		ret_ip         <= $random(seed);
		ret_next_ip    <= $random(seed);
		ret_target_ip  <= $random(seed);
		{ret_taken, ret_rep, ret_rep_last, exc_gpr_dirty} <= r[3:0];
		gate_is_maskable_interrupt_pin   <= r[4];
		exc_vector     <= r[15:8];
		int_vector     <= vec2 ? NMI_VEC : r[23:16];
		flags_register <= {r[31:10], ie, r[8:0]};
	endtask

	// Drop requests after the taking edge and let outputs settle
	task automatic fire;
		@(posedge mclk);
		{ret_valid, exc_valid, ret_spec, ret_interrupt_return_instruction} <= 4'h0;
		maskable_interrupt_pin <= 1'b0;
		#1;
		rip = ret_rep && !ret_rep_last ? ret_ip
			: ret_taken ? ret_target_ip : ret_next_ip;
	endtask

	// Ask the source model for a pin edge or a message
	task automatic src(input logic p, m);
		@(posedge mclk);
		pin_req <= p;
		msg_req <= m;
		@(posedge mclk);
		pin_req <= 1'b0;
		msg_req <= 1'b0;
	endtask

	// Watchdog
	initial begin
		repeat (8000) @(posedge mclk);
		errors++;
		tally_and_finish;
	end

	initial begin
		{ret_valid, ret_boundary, ret_spec, ret_taken, ret_rep} = 5'h00;
		{ret_rep_last, ret_interrupt_return_instruction, exc_valid, exc_gpr_dirty} = 4'h0;
		{gate_is_maskable_interrupt_pin, maskable_interrupt_pin, pin_req, msg_req} = 4'h0;
		{ret_ip, ret_next_ip, ret_target_ip} = '0;
		{exc_vector, int_vector, flags_register, vec2} = '0;
		exc_class = EXRN_FAULT;
		rst = 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 30; i++) begin
			// Each exception class, with the return point for fault and trap
			arm(1'b1, 1'b1, 1'b1);
			exc_class <= exrn_class_t'(i % 3);
			fire;
			chk(dlv_kind, EXRN_K_EXC);
			chk(dlv_vector, exc_vector);
			chk(rollback, i % 3 == 0);
			chk(save_regs, i % 3 == 0);
			chk(dlv_precise, i % 3 != 2);
			chk(dlv_restartable, i % 3 == 1 || i % 3 == 0 && !exc_gpr_dirty);
			if (i % 3 < 2)
				chk(dlv_return_ip, i % 3 ? (ret_taken ? ret_target_ip
					: ret_next_ip) : ret_ip);
			// Off boundary, speculative or masked requests give nothing
			arm(i % 3 != 2, i % 3 != 0, i % 3 != 2);
			ret_spec <= i % 3 == 1;
			maskable_interrupt_pin <= i % 3 != 1;
			exc_class <= exrn_class_t'(i % 2);
			fire;
			chk(dlv_valid, 1'b0);
			// Maskable delivery, vector two included
			vec2 = i < 4;
			arm(1'b0, 1'b1, 1'b1);
			maskable_interrupt_pin <= 1'b1;
			fire;
			chk(dlv_kind, EXRN_K_INT);
			chk(int_ack, 1'b1);
			chk(dlv_vector, int_vector);
			chk(dlv_return_ip, rip);
			chk(dlv_clear_ie, gate_is_maskable_interrupt_pin);
			chk(nmi_blocked, 1'b0);
			// Non-maskable from pin or message with the enable clear
			src(i % 2 == 0, i % 2 == 1);
			arm(1'b0, 1'b1, 1'b0);
			fire;
			chk(dlv_kind, EXRN_K_NMI);
			chk(dlv_vector, NMI_VEC);
			chk(dlv_return_ip, rip);
			chk(nmi_blocked & in_nmi_handler, 1'b1);
			// Inside the handler a new pin edge and a maskable one wait
			src(1'b1, 1'b0);
			arm(1'b0, 1'b1, 1'b1);
			maskable_interrupt_pin <= 1'b1;
			fire;
			chk(dlv_valid, 1'b0);
			// A faulting return still unblocks; the held edge then lands
			arm(1'b1, 1'b1, 1'b0);
			exc_class <= EXRN_FAULT;
			ret_interrupt_return_instruction <= 1'b1;
			fire;
			chk(dlv_kind, EXRN_K_EXC);
			chk(nmi_blocked, 1'b0);
			arm(1'b0, 1'b1, 1'b0);
			fire;
			chk(dlv_kind, EXRN_K_NMI);
			// A plain return closes the handler
			arm(1'b0, 1'b1, 1'b0);
			ret_interrupt_return_instruction <= 1'b1;
			fire;
			chk(dlv_valid, 1'b0);
			chk(nmi_blocked | in_nmi_handler, 1'b0);
		end
		tally_and_finish;
	end
endmodule // exrn_unit_tb

//--- rtl/exrn_nmi_gate.sv
// Non-maskable request capture and blocking
`timescale 1ns/1ps
module exrn_nmi_gate (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Sources
	input  wire logic nmi_pin,
	input  wire logic nmi_msg,
	// Control from the main unit
	input  wire logic take,
	input  wire logic interrupt_return_instruction_done,
	// Status
	output logic      pending,
	output logic      blocked
);
	import exrn_pkg::*;

	typedef struct packed {
		logic pend;
		logic blk;
		logic pin_prev;
	} exrn_ng_t;

	exrn_ng_t s_q;
	exrn_ng_t s_d;
	logic     rise;

	assign rise = nmi_pin & ~s_q.pin_prev;

	// Pending capture and blocking until the return instruction
	always_comb begin
		s_d = s_q;
		s_d.pin_prev = nmi_pin;
		if (take)
			s_d.pend = 1'b0;
		if (rise | nmi_msg)
			s_d.pend = 1'b1;  // Set wins over take [RQ14] [RQ23]
		if (take)
			s_d.blk = 1'b1;   // [RQ18]
		else if (interrupt_return_instruction_done)
			s_d.blk = 1'b0;   // Even a faulting return unblocks [RQ20]
	end

	always_ff @(posedge mclk) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign pending = s_q.pend;
	assign blocked = s_q.blk;

	// Held request waits while blocked [RQ23]
	pend_held_a: assert property (@(posedge mclk) disable iff (rst)
		s_q.pend && s_q.blk && !take |=> s_q.pend) // [RQ23]
		else $error("pending request lost while blocked");
	// Blocking ends only on a return instruction
	blk_hold_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(s_q.blk) |-> $past(interrupt_return_instruction_done)) // [RQ18]
		else $error("blocking cleared without return");
endmodule // exrn_nmi_gate

//--- rtl/exrn_pkg.sv
// Package for the exception restart and non-maskable interrupt unit
package exrn_pkg;
	localparam int AW = 32;                       // Instruction pointer width
	localparam int VW = 8;                        // Vector width
	localparam int FW = 32;                       // Flags register width
	localparam logic [7:0] NMI_VEC = 8'h02;       // Non-maskable vector
	localparam int IE_BIT = 9;                    // Interrupt-enable flag bit
	localparam int VM_BIT = 17;                   // Virtual-8086 flag bit
	localparam logic [1:0] IO_PRIVILEGE_LEVEL_MAX = 2'h3;       // Top privilege level
	localparam logic [31:0] ZERO_AW = 32'h0;
	localparam logic [7:0] ZERO_VW = 8'h00;

	// Exception class as reported by the retirement logic
	typedef enum logic [1:0] {
		EXRN_FAULT = 2'h0,
		EXRN_TRAP  = 2'h1,
		EXRN_ABORT = 2'h2
	} exrn_class_t;

	// Kind of event that was delivered
	typedef enum logic [1:0] {
		EXRN_K_NONE = 2'h0,
		EXRN_K_EXC  = 2'h1,
		EXRN_K_INT  = 2'h2,
		EXRN_K_NMI  = 2'h3
	} exrn_kind_t;

	// Controller states; Gray along idle, deliver, in handler
	typedef enum logic [1:0] {
		EXRN_IDLE = 2'h0,
		EXRN_DLV  = 2'h1,
		EXRN_HND  = 2'h3
	} exrn_state_t;
endpackage

//--- rtl/exrn_unit.sv
// Exception restart and non-maskable interrupt unit, main logic
`timescale 1ns/1ps
// Overview of operation
// RQ1: Fault rolls machine state back before instruction
// RQ2: Fault return address is faulting instruction
// RQ3: Trap reported after instruction, returns to next
// RQ4: Trap on control transfer returns to target
// RQ5: Abort is imprecise and not restartable
// RQ6: Non-abort exceptions only at instruction boundaries
// RQ7: Interrupts accepted only at instruction boundaries
// RQ8: Interrupt return pointer is next instruction
// RQ9: Repeat prefix: interrupt after current iteration
// RQ10: Boundaries come from retirement, in order
// RQ11: No events from prefetch or early decode
// RQ12: Keep registers and stack for fault restart
// RQ13: Fault with modified registers is non-restartable
// RQ14: Non-maskable from pin or bus message
// RQ15: Non-maskable serviced at once through vector two
// RQ16: Interrupt-enable flag ignores non-maskable requests
// RQ17: Maskable vector two skips non-maskable hardware
// RQ18: Block further non-maskable until return instruction
// RQ19: Block other interrupts during non-maskable handler
// RQ20: Return instruction unblocks even when faulting
// RQ21: Software uses interrupt gate for handler
// RQ22: Interrupt gate clears enable flag; trap doesn't
// RQ23: Hold pin request while blocked, deliver later
module exrn_unit (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// Retirement port
	input  wire logic                     ret_valid,
	input  wire logic                     ret_boundary,
	input  wire logic                     ret_spec,
	input  wire logic [exrn_pkg::AW-1:0]  ret_ip,
	input  wire logic [exrn_pkg::AW-1:0]  ret_next_ip,
	input  wire logic                     ret_taken,
	input  wire logic [exrn_pkg::AW-1:0]  ret_target_ip,
	input  wire logic                     ret_rep,
	input  wire logic                     ret_rep_last,
	input  wire logic                     ret_interrupt_return_instruction,
	// Exception report from execution
	input  wire logic                     exc_valid,
	input  wire exrn_pkg::exrn_class_t    exc_class,
	input  wire logic [exrn_pkg::VW-1:0]  exc_vector,
	input  wire logic                     exc_gpr_dirty,
	// Interrupt sources
	input  wire logic                     nmi_pin,
	input  wire logic                     nmi_msg,
	input  wire logic                     maskable_interrupt_pin,
	input  wire logic [exrn_pkg::VW-1:0]  int_vector,
	// Flags and gate type
	input  wire logic [exrn_pkg::FW-1:0]  flags_register,
	input  wire logic                     gate_is_maskable_interrupt_pin,
	// Delivery to the saved-state logic
	output logic                          dlv_valid,
	output exrn_pkg::exrn_kind_t          dlv_kind,
	output logic [exrn_pkg::VW-1:0]       dlv_vector,
	output logic [exrn_pkg::AW-1:0]       dlv_return_ip,
	output logic                          dlv_restartable,
	output logic                          dlv_precise,
	output logic                          dlv_clear_ie,
	output logic                          rollback,
	output logic                          save_regs,
	output logic                          int_ack,
	// Status
	output logic                          nmi_blocked,
	output logic                          in_nmi_handler
);
	import exrn_pkg::*;

	// Return address for an exception of the given class
	function automatic logic [AW-1:0] ret_addr(
		input exrn_class_t c, input logic [AW-1:0] ip,
		input logic [AW-1:0] nxt, input logic tk,
		input logic [AW-1:0] tgt);
		logic [AW-1:0] r;
		r = ip;
		if (c == EXRN_TRAP)
			r = tk ? tgt : nxt;
		return r;
	endfunction

	typedef struct packed {
		exrn_state_t   st;
		logic          v;
		exrn_kind_t    kind;
		logic [VW-1:0] vec;
		logic [AW-1:0] rip;
		logic          rst_ok;
		logic          prec;
		logic          clr_ie;
		logic          rb;
		logic          sv;
		logic          ack;
		logic          in_nmi;
	} exrn_st_t;

	exrn_st_t s_q;
	exrn_st_t s_d;

	logic nmi_pend;
	logic nmi_blk;
	logic nmi_take;
	logic interrupt_return_instruction_done;
	logic bnd;
	logic ie;

	// In-order boundary from retirement only; speculation ignored
	assign bnd = ret_valid & ret_boundary & ~ret_spec; // [RQ10] [RQ11]
	assign ie  = flags_register[IE_BIT];
	// Return retiring, including one that faults in virtual-8086 mode
	assign interrupt_return_instruction_done = ret_valid & ~ret_spec & ret_interrupt_return_instruction; // [RQ20]

	exrn_nmi_gate u_gate (
		.mclk      (mclk),
		.rst       (rst),
		.nmi_pin   (nmi_pin),
		.nmi_msg   (nmi_msg),
		.take      (nmi_take),
		.interrupt_return_instruction_done (interrupt_return_instruction_done),
		.pending   (nmi_pend),
		.blocked   (nmi_blk)
	);

	// Non-maskable taken at a boundary, ignoring the enable flag
	assign nmi_take = bnd & nmi_pend & ~nmi_blk & ~exc_valid &
		(s_q.st != EXRN_DLV); // [RQ15] [RQ16] [RQ7]

	// Delivery selection
	always_comb begin
		s_d = s_q;
		s_d.v   = 1'b0;
		s_d.rb  = 1'b0;
		s_d.sv  = 1'b0;
		s_d.ack = 1'b0;
		case (s_q.st)
			EXRN_IDLE, EXRN_HND: begin
				if (interrupt_return_instruction_done) begin
					s_d.in_nmi = 1'b0; // [RQ20]
					s_d.st     = EXRN_IDLE;
				end
				if (ret_valid && !ret_spec && exc_valid &&
					(ret_boundary || exc_class == EXRN_ABORT)) begin
					// Exceptions at boundaries; aborts anywhere [RQ6] [RQ11]
					s_d.v    = 1'b1;
					s_d.kind = EXRN_K_EXC;
					s_d.vec  = exc_vector;
					s_d.rip  = ret_addr(exc_class, ret_ip, ret_next_ip,
						ret_taken, ret_target_ip); // [RQ2] [RQ3] [RQ4]
					s_d.rb   = (exc_class == EXRN_FAULT); // [RQ1]
					s_d.sv   = (exc_class == EXRN_FAULT); // [RQ12]
					// Abort and dirty-register fault are not restartable
					s_d.rst_ok = (exc_class != EXRN_ABORT) &&
						!(exc_class == EXRN_FAULT && exc_gpr_dirty); // [RQ5] [RQ13]
					s_d.prec = (exc_class != EXRN_ABORT); // [RQ5]
					s_d.clr_ie = gate_is_maskable_interrupt_pin; // [RQ22]
					s_d.st   = EXRN_DLV;
				end else if (nmi_take) begin
					s_d.v      = 1'b1;
					s_d.kind   = EXRN_K_NMI;
					s_d.vec    = NMI_VEC; // [RQ15]
					s_d.rip    = (ret_rep && !ret_rep_last) ? ret_ip :
						(ret_taken ? ret_target_ip : ret_next_ip); // [RQ8] [RQ9]
					s_d.rst_ok = 1'b1;
					s_d.prec   = 1'b1;
					s_d.clr_ie = gate_is_maskable_interrupt_pin; // [RQ22]
					s_d.in_nmi = 1'b1;
					s_d.st     = EXRN_DLV;
				end else if (bnd && maskable_interrupt_pin && ie &&
					!s_q.in_nmi && !nmi_blk) begin
					// Vector two here is an ordinary interrupt [RQ17] [RQ19]
					s_d.v      = 1'b1;
					s_d.kind   = EXRN_K_INT;
					s_d.vec    = int_vector;
					s_d.rip    = (ret_rep && !ret_rep_last) ? ret_ip :
						(ret_taken ? ret_target_ip : ret_next_ip); // [RQ8] [RQ9]
					s_d.rst_ok = 1'b1;
					s_d.prec   = 1'b1;
					s_d.clr_ie = gate_is_maskable_interrupt_pin; // [RQ22]
					s_d.ack    = 1'b1;
					s_d.st     = EXRN_DLV;
				end
			end
			EXRN_DLV: begin
				s_d.st = s_q.in_nmi ? EXRN_HND : EXRN_IDLE;
			end
			default: s_d.st = EXRN_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '{st: EXRN_IDLE, kind: EXRN_K_NONE, vec: ZERO_VW,
				rip: ZERO_AW, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Registered outputs
	assign dlv_valid       = s_q.v;
	assign dlv_kind        = s_q.kind;
	assign dlv_vector      = s_q.vec;
	assign dlv_return_ip   = s_q.rip;
	assign dlv_restartable = s_q.rst_ok;
	assign dlv_precise     = s_q.prec;
	assign dlv_clear_ie    = s_q.clr_ie;
	assign rollback        = s_q.rb;
	assign save_regs       = s_q.sv;
	assign int_ack         = s_q.ack;
	assign nmi_blocked     = nmi_blk;
	assign in_nmi_handler  = s_q.in_nmi;

	// Fault returns to the faulting instruction with rollback
	fault_ret_a: assert property (@(posedge mclk) disable iff (rst)
		ret_valid && !ret_spec && ret_boundary && exc_valid &&
		exc_class == EXRN_FAULT && s_q.st != EXRN_DLV
		|=> dlv_valid && rollback && dlv_return_ip == $past(ret_ip)) // [RQ2]
		else $error("fault return address wrong");
	// Trap on taken transfer returns to target
	trap_ret_a: assert property (@(posedge mclk) disable iff (rst)
		ret_valid && !ret_spec && ret_boundary && exc_valid &&
		exc_class == EXRN_TRAP && s_q.st != EXRN_DLV
		|=> dlv_return_ip == ($past(ret_taken) ? $past(ret_target_ip)
			: $past(ret_next_ip))) // [RQ4]
		else $error("trap return address wrong");
	// Abort is never restartable
	abort_flag_a: assert property (@(posedge mclk) disable iff (rst)
		dlv_valid && dlv_kind == EXRN_K_EXC && !dlv_precise
		|-> !dlv_restartable) // [RQ5]
		else $error("abort reported restartable");
	// Non-maskable always uses vector two
	nmi_vec_a: assert property (@(posedge mclk) disable iff (rst)
		dlv_valid && dlv_kind == EXRN_K_NMI |-> dlv_vector == NMI_VEC) // [RQ15]
		else $error("non-maskable vector wrong");
	// Nothing is delivered off a boundary except aborts
	sequence bad_slot_s;
		!(ret_valid && ret_boundary && !ret_spec);
	endsequence
	bnd_only_a: assert property (@(posedge mclk) disable iff (rst)
		bad_slot_s |=> !(dlv_valid && dlv_precise)) // [RQ6] [RQ7]
		else $error("delivery off a boundary");
	// Non-maskable taken even with enable flag clear
	nmi_ie_a: assert property (@(posedge mclk) disable iff (rst)
		nmi_take |=> dlv_valid && dlv_kind == EXRN_K_NMI) // [RQ16]
		else $error("non-maskable not delivered");
	// No maskable delivery inside the non-maskable handler
	sequence in_nmi_s;
		in_nmi_handler ##1 dlv_valid;
	endsequence
	no_nest_a: assert property (@(posedge mclk) disable iff (rst)
		in_nmi_s |-> dlv_kind != EXRN_K_INT) // [RQ19]
		else $error("maskable taken during handler");
	// Return instruction clears blocking next cycle
	interrupt_return_instruction_clr_a: assert property (@(posedge mclk) disable iff (rst)
		interrupt_return_instruction_done && !nmi_take |=> !nmi_blocked) // [RQ20]
		else $error("return did not unblock");
endmodule // exrn_unit
